// ==== src/cxf_pkg.sv ====
// package for the call and file-op execution block
// assumes a 14-bit instruction word and a 15-bit program counter
package cxf_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int PC_W = 15;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int INSN_W = 14;
    // ------------------------------------------------------------
    // operation codes presented by the front end
    // ------------------------------------------------------------
    localparam logic [3:0] OP_NONE = 4'h0;
    localparam logic [3:0] OP_CALL_VIA_ACC = 4'h1;
    localparam logic [3:0] OP_COMPLEMENT_FILE = 4'h2;
    localparam logic [3:0] OP_CLEAR_FILE = 4'h3;
    localparam logic [3:0] OP_CLEAR_ACC = 4'h4;
    localparam logic [3:0] OP_DECREMENT_FILE = 4'h5;
    localparam logic [3:0] OP_DEC_SKIP_ZERO = 4'h6;
    localparam logic [3:0] OP_INC_SKIP_ZERO = 4'h7;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [14:0] PC_RESET = 15'h0000;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [14:0] PC_ONE = 15'h0001;
    localparam int LATCH_LOW_BITS = 7;
    typedef enum logic [2:0] {
        CXF_RUN = 3'b001,
        CXF_CALL2 = 3'b010,
        CXF_SKIP = 3'b100
    } cxf_state_t;
endpackage

// ==== src/cxf_exec.sv ====
// execution unit: call via accumulator and file-register operations
// assumes file_rdata_i is combinational for the op_file_i address
// presented with op_valid_i, and that an external stack
// stores push_data_o on push_o
//
// Contract
// - call pushes pc plus one to stack
// - pc low from accumulator, high from latch
// - call takes two cycles, flags unchanged
// - destination bit one writes file register
// - complement inverts file, updates zero flag
// - complement with d zero writes accumulator
// - clear file writes zero, sets zero
// - clear accumulator writes zero, sets zero
// - decrement file subtracts one, zero flag
// - decrement skip keeps flags, no skip nonzero
// - decrement skip zero result skips next
// - increment skip adds one, flags unchanged
// - increment skip wraps zero, skips next
// - skip discards fetched instruction as nop
`timescale 1ns/1ns
module cxf_exec #(
    parameter int PC_W = cxf_pkg::PC_W,
    parameter int DATA_W = cxf_pkg::DATA_W,
    parameter int ADDR_W = cxf_pkg::ADDR_W
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input wire logic [3:0] op_code_i,
    input wire logic [ADDR_W-1:0] op_file_i,
    input wire logic op_dest_i,
    input wire logic [DATA_W-1:0] file_rdata_i,
    input wire logic [DATA_W-1:0] pc_high_latch_i,
    input wire logic [DATA_W-1:0] acc_load_i,
    input wire logic acc_load_en_i,
    output logic [PC_W-1:0] pc_o,
    output logic [DATA_W-1:0] acc_o,
    output logic zero_flag_o,
    output logic file_we_o,
    output logic [ADDR_W-1:0] file_addr_o,
    output logic [DATA_W-1:0] file_wdata_o,
    output logic push_o,
    output logic [PC_W-1:0] push_data_o,
    output logic busy_o,
    output logic squash_o
);
    // ------------------------------------------------------------
    // next-value decode
    // ------------------------------------------------------------
    cxf_pkg::cxf_state_t state_r;
    cxf_pkg::cxf_state_t state_nxt;
    logic take;
    logic [DATA_W-1:0] result;
    logic to_file;
    logic to_acc;
    logic zero_upd;
    logic zero_val;
    logic skip_req;

    function automatic logic is_zero(input logic [DATA_W-1:0] v);
        return v == cxf_pkg::ZERO_BYTE;
    endfunction

    // nothing is accepted while a call or skip slot is in progress
    assign take = op_valid_i && (state_r == cxf_pkg::CXF_RUN);

    always_comb begin
        result = cxf_pkg::ZERO_BYTE;
        to_file = 1'b0;
        to_acc = 1'b0;
        zero_upd = 1'b0;
        zero_val = 1'b0;
        skip_req = 1'b0;
        unique case (op_code_i)
            cxf_pkg::OP_COMPLEMENT_FILE: begin
                result = ~file_rdata_i;
                to_file = op_dest_i;
                to_acc = !op_dest_i;
                zero_upd = 1'b1;
                zero_val = is_zero(result);
            end
            cxf_pkg::OP_CLEAR_FILE: begin
                result = cxf_pkg::ZERO_BYTE;
                to_file = 1'b1;
                zero_upd = 1'b1;
                zero_val = 1'b1;
            end
            cxf_pkg::OP_CLEAR_ACC: begin
                result = cxf_pkg::ZERO_BYTE;
                to_acc = 1'b1;
                zero_upd = 1'b1;
                zero_val = 1'b1;
            end
            cxf_pkg::OP_DECREMENT_FILE: begin
                result = file_rdata_i - cxf_pkg::ONE_BYTE;
                to_file = op_dest_i;
                to_acc = !op_dest_i;
                zero_upd = 1'b1;
                zero_val = is_zero(result);
            end
            cxf_pkg::OP_DEC_SKIP_ZERO: begin
                result = file_rdata_i - cxf_pkg::ONE_BYTE;
                to_file = op_dest_i;
                to_acc = !op_dest_i;
                skip_req = is_zero(result);
            end
            cxf_pkg::OP_INC_SKIP_ZERO: begin
                result = file_rdata_i + cxf_pkg::ONE_BYTE;
                to_file = op_dest_i;
                to_acc = !op_dest_i;
                skip_req = is_zero(result);
            end
            default: begin
                result = cxf_pkg::ZERO_BYTE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            cxf_pkg::CXF_RUN: begin
                if (take && op_code_i == cxf_pkg::OP_CALL_VIA_ACC) begin
                    state_nxt = cxf_pkg::CXF_CALL2;
                end else if (take && skip_req) begin
                    state_nxt = cxf_pkg::CXF_SKIP;
                end
            end
            cxf_pkg::CXF_CALL2: begin
                state_nxt = cxf_pkg::CXF_RUN;
            end
            cxf_pkg::CXF_SKIP: begin
                state_nxt = cxf_pkg::CXF_RUN;
            end
            default: begin
                state_nxt = cxf_pkg::CXF_RUN;
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_r <= cxf_pkg::CXF_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            squash_o <= 1'b0;
        end else begin
            busy_o <= (state_nxt != cxf_pkg::CXF_RUN);
            // the fetched word is thrown away, a nop fills the slot
            squash_o <= (state_nxt == cxf_pkg::CXF_SKIP);
        end
    end

    // ------------------------------------------------------------
    // program counter and return stack
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            pc_o <= cxf_pkg::PC_RESET;
            push_o <= 1'b0;
            push_data_o <= cxf_pkg::PC_RESET;
        end else begin
            push_o <= 1'b0;
            if (take && op_code_i == cxf_pkg::OP_CALL_VIA_ACC) begin
                push_o <= 1'b1;
                push_data_o <= pc_o + cxf_pkg::PC_ONE;
                pc_o <= {pc_high_latch_i[cxf_pkg::LATCH_LOW_BITS-1:0],
                         acc_o};
            end else if (take || state_r != cxf_pkg::CXF_CALL2) begin
                // one word per cycle, the skip slot advances too
                pc_o <= pc_o + cxf_pkg::PC_ONE;
            end
        end
    end

    // ------------------------------------------------------------
    // accumulator and zero flag
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            acc_o <= cxf_pkg::ACC_RESET;
        end else if (take && to_acc) begin
            acc_o <= result;
        end else if (acc_load_en_i) begin
            acc_o <= acc_load_i;
        end
    end

    // skip ops and the call leave the flag alone
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            zero_flag_o <= 1'b0;
        end else if (take && zero_upd) begin
            zero_flag_o <= zero_val;
        end
    end

    // ------------------------------------------------------------
    // file write port
    // ------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            file_we_o <= 1'b0;
            file_addr_o <= '0;
            file_wdata_o <= cxf_pkg::ZERO_BYTE;
        end else begin
            file_we_o <= take && to_file;
            if (take) begin
                file_addr_o <= op_file_i;
                file_wdata_o <= result;
            end
        end
    end
endmodule // cxf_exec

// ==== test/cxf_exec_properties.sv ====
// checker for cxf_exec: call and skip slots, file and flag results
// assumes it is bound to cxf_exec; an op is taken while busy_o is low
`timescale 1ns/1ns
module cxf_exec_chk (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic op_valid_i,
    input wire logic [3:0] op_code_i,
    input wire logic [6:0] op_file_i,
    input wire logic op_dest_i,
    input wire logic [7:0] file_rdata_i,
    input wire logic [7:0] pc_high_latch_i,
    input wire logic [14:0] pc_o,
    input wire logic [7:0] acc_o,
    input wire logic zero_flag_o,
    input wire logic file_we_o,
    input wire logic [6:0] file_addr_o,
    input wire logic [7:0] file_wdata_o,
    input wire logic busy_o,
    input wire logic squash_o,
    input wire logic push_o,
    input wire logic [14:0] push_data_o
);
    // ------------------------------------------------------------
    // decoded takes
    // ------------------------------------------------------------
    logic tk, c_call, c_complement_file, c_clear_file, c_clear_accumulator, c_dec, c_dsz, c_isz, c_sk;
    assign tk = op_valid_i && !busy_o;
    assign c_call = tk && op_code_i == cxf_pkg::OP_CALL_VIA_ACC;
    assign c_complement_file = tk && op_code_i == cxf_pkg::OP_COMPLEMENT_FILE;
    assign c_clear_file = tk && op_code_i == cxf_pkg::OP_CLEAR_FILE;
    assign c_clear_accumulator = tk && op_code_i == cxf_pkg::OP_CLEAR_ACC;
    assign c_dec = tk && op_code_i == cxf_pkg::OP_DECREMENT_FILE;
    assign c_dsz = tk && op_code_i == cxf_pkg::OP_DEC_SKIP_ZERO;
    assign c_isz = tk && op_code_i == cxf_pkg::OP_INC_SKIP_ZERO;
    // skip only when the eight-bit result comes out zero
    assign c_sk = (c_dsz && file_rdata_i == 8'h01)
        || (c_isz && file_rdata_i == 8'hFF);
    default clocking @(posedge clock_i);
    endclocking
    default disable iff (rst_i);
    chk_call_push: assert property (c_call |=> push_o
        && push_data_o == $past(pc_o) + 15'h0001) else $error("call push");
    chk_call_dest: assert property (c_call |=> pc_o ==
        {$past(pc_high_latch_i[6:0]), $past(acc_o)}) else $error("call pc");
    chk_call_slot: assert property (c_call |=> busy_o ##1 !busy_o)
        else $error("call slot");
    chk_flag_keep:
        assert property (c_call || c_dsz || c_isz |=> $stable(zero_flag_o))
        else $error("flag moved");
    chk_dest_write:
        assert property ((c_complement_file || c_dec || c_dsz || c_isz) && op_dest_i
        |=> file_we_o && file_addr_o == $past(op_file_i)) else $error("dest");
    chk_comp_route: assert property (c_complement_file && !op_dest_i |=>
        !file_we_o && acc_o == ~$past(file_rdata_i)) else $error("comp");
    chk_clear_file: assert property (c_clear_file |=> file_we_o
        && file_wdata_o == 8'h00 && zero_flag_o) else $error("clear file");
    chk_clear_acc: assert property (c_clear_accumulator |=> acc_o == 8'h00
        && zero_flag_o && !file_we_o) else $error("clear acc");
    chk_dec_zero: assert property (c_dec |=>
        zero_flag_o == ($past(file_rdata_i) == 8'h01)) else $error("dec z");
    chk_skip_slot:
        assert property (c_sk |=> squash_o && busy_o ##1 !squash_o)
        else $error("skip slot");
    chk_no_skip: assert property ((c_dsz || c_isz) && !c_sk |=>
        !squash_o && !busy_o) else $error("false skip");
endmodule // cxf_exec_chk
bind cxf_exec cxf_exec_chk u_chk (.*);

// ==== test/cxf_exec_tb.sv ====
// bench for cxf_exec: corner and seeded random ops, self-checking
// assumes cxf_exec answers at the edge after it takes an op
`timescale 1ns/1ns
module cxf_exec_tb;
    logic clock_i = 1'b0, rst_i = 1'b1, op_valid_i = 1'b0, op_dest_i = 1'b0;
    logic acc_load_en_i = 1'b0, zero_flag_o, file_we_o, busy_o, squash_o;
    logic push_o;
    logic [3:0] op_code_i = 4'h0;
    logic [6:0] op_file_i = 7'h00, file_addr_o;
    logic [7:0] file_rdata_i = 8'h00, pc_high_latch_i = 8'h00;
    logic [7:0] acc_load_i = 8'h00, acc_o, file_wdata_o;
    logic [14:0] pc_o, push_data_o;
    int err_count = 0, n_tests = 0, seed = 32'h722E1FE7;
    cxf_exec u_dut (.*);
    initial begin
        forever #10 clock_i = ~clock_i;
    end
    task automatic check(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic final_report;
        if (err_count == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic load_acc(input logic [7:0] v);
        @(posedge clock_i);
        acc_load_en_i <= 1'b1;
        acc_load_i <= v;
        @(posedge clock_i);
        acc_load_en_i <= 1'b0;
        #1 check(acc_o === v, "acc load");
    endtask
    task automatic run_op(input logic [3:0] op, input logic [7:0] fd,
                          input logic d);
        logic [14:0] p0;
        logic [7:0] a0, r, ea;
        logic [6:0] f, l;
        logic z0, ez, we, cl, sk;
        for (int i = 0; i < 4 && busy_o !== 1'b0; i++) #20;
        if (busy_o !== 1'b0) begin
            err_count++;
            final_report;
        end
        f = 7'($random(seed));
        l = 7'($random(seed));
        @(posedge clock_i);
        op_valid_i <= 1'b1;
        op_code_i <= op;
        op_dest_i <= d;
        op_file_i <= f;
        file_rdata_i <= fd;
        pc_high_latch_i <= {fd[0], l};
        #1;
        p0 = pc_o;
        a0 = acc_o;
        z0 = zero_flag_o;
        cl = op == cxf_pkg::OP_CALL_VIA_ACC;
        r = op == cxf_pkg::OP_COMPLEMENT_FILE ? ~fd : 8'h00;
        if (op inside {cxf_pkg::OP_DECREMENT_FILE, cxf_pkg::OP_DEC_SKIP_ZERO})
            r = fd - 8'h01;
        if (op == cxf_pkg::OP_INC_SKIP_ZERO)
            r = fd + 8'h01;
        we = op == cxf_pkg::OP_CLEAR_FILE;
        we = we || (d && !cl && op != cxf_pkg::OP_CLEAR_ACC);
        sk = op >= cxf_pkg::OP_DEC_SKIP_ZERO && r == 8'h00;
        ea = (we || cl) ? a0 : r;
        ez = (cl || op >= cxf_pkg::OP_DEC_SKIP_ZERO) ? z0 : r == 8'h00;
        // busy slot gets a clear op that must be ignored
        @(posedge clock_i);
        op_valid_i <= cl || sk;
        op_code_i <= cxf_pkg::OP_CLEAR_ACC;
        #1;
        check(pc_o === (cl ? {l, a0} : p0 + 15'h0001), "pc");
        check(push_o === cl && (!cl || push_data_o === p0 + 15'h0001), "push");
        check(busy_o === (cl || sk) && squash_o === sk, "slot");
        check(file_we_o === we && (!we || file_wdata_o === r), "file");
        check(!we || file_addr_o === f, "addr");
        check(acc_o === ea, "acc");
        check(zero_flag_o === ez, "zero");
        if (cl || sk) begin
            @(posedge clock_i);
            op_valid_i <= 1'b0;
            #1;
            check(busy_o === 1'b0 && squash_o === 1'b0 && acc_o === ea, "nop");
            check(pc_o === (cl ? {l, a0} : p0 + 15'h0002), "pc slot");
        end
    endtask
    initial begin
        logic [3:0] op;
        logic [7:0] fd;
        repeat (5) @(posedge clock_i);
        rst_i <= 1'b0;
        #1 check(pc_o === 15'h0000 && acc_o === 8'h00, "reset");
        load_acc(8'hA5);
        for (int k = 1; k < 8; k++) begin
            run_op(4'(k), 8'h01, 1'b1);
            run_op(4'(k), 8'hFF, 1'b0);
            run_op(4'(k), 8'h00, 1'b1);
        end
        for (int k = 0; k < 300; k++) begin
            op = 4'h1 + 4'($unsigned($random(seed)) % 7);
            fd = 8'($random(seed));
            if (fd[7:5] == 3'b000)
                fd = fd[0] ? 8'hFF : 8'h01;
            if (k % 16 == 0)
                load_acc(8'($random(seed)));
            run_op(op, fd, 1'($random(seed)));
        end
        final_report;
    end
endmodule // cxf_exec_tb
